// ### dv/lifetime_extreme_logger_tb.sv
// self-checking bench for the lifetime extreme logger
// assumes a short second of 10 clocks so 60 s windows stay brief
`timescale 1ns/1ns

module lifetime_extreme_logger_tb;
	localparam int CPS = 10;
	logic                              i_ref_clk;
	logic                              i_sys_rst;
	logic                              cmd_valid;
	logic [15:0]                       cmd_code;
	logic                              unlocked;
	logic [7:0]                        block_sel;
	lifetime_log_pkg::sample_t         smp;
	lifetime_log_pkg::access_t         acc;
	logic [15:0]                       rdata;
	logic                              ack;
	logic                              refused;
	logic                              flag;
	logic                              nv_write;
	logic [15:0]                       wr_count;
	lifetime_log_pkg::extreme_table_t  nv_tab;
	int n_mismatch = 0;
	int n_checks   = 0;
	int cyc        = 0;
	int last_wr    = 0;
	int n_wr       = 0;
	int sto[6]     = '{0, 500, 2800, 5000, 0, 0};
	int run[6];
	int res_t = 10, res_v = 25, res_c = 100, ivl = 60;
	bit en = 0;
	logic [1:0]  an;
	logic [15:0] rd;
	int rnd;

	lifetime_extreme_logger #(.CYCLES_PER_SECOND(CPS)) dut (
		.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
		.i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code),
		.i_unlocked(unlocked), .i_block_select(block_sel),
		.i_sample(smp), .i_access(acc), .o_rdata(rdata), .o_ack(ack),
		.o_refused(refused), .o_gauging_enabled_flag(flag),
		.o_nv_write(nv_write), .o_log_write_counter(wr_count),
		.o_nv_table(nv_tab));

	lifetime_host_model host (
		.i_ref_clk(i_ref_clk), .i_ack(ack), .i_refused(refused),
		.i_rdata(rdata), .o_cmd_valid(cmd_valid), .o_cmd_code(cmd_code),
		.o_unlocked(unlocked), .o_block_select(block_sel), .o_access(acc));

	// clock and cycle count
	initial begin
		i_ref_clk = 1'b0;
		forever #2 i_ref_clk = ~i_ref_clk;
	end
	always @(posedge i_ref_clk) cyc <= cyc + 1;

	// one comparison
	task automatic chk(input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	// access with expected answer {ack,refused} and read data
	task automatic xs(input logic wr, input logic unl, input logic [7:0] blk,
			input logic [7:0] sub, input logic [7:0] off,
			input logic [15:0] wd, input logic [1:0] ea,
			input logic [15:0] ed);
		host.access(wr, unl, blk, sub, off, wd, an, rd);
		chk({14'h0000, ea}, {14'h0000, an});
		if (ea == 2'b10 && !wr) begin
			chk(ed, rd);
		end
	endtask

	// sample to the design and the running-table model
	task automatic sample(input int t, input int v, input int c);
		int tc;
		tc = (t < -600) ? -600 : (t > 1400) ? 1400 : t;
		@(posedge i_ref_clk);
		smp <= {1'b1, t[15:0], v[15:0], c[15:0]};
		@(posedge i_ref_clk);
		smp.valid <= 1'b0;
		if (en && ivl != 0) begin
			run[0] = (tc > run[0]) ? tc : run[0];
			run[1] = (tc < run[1]) ? tc : run[1];
			run[2] = (v > run[2]) ? v : run[2];
			run[3] = (v < run[3]) ? v : run[3];
			run[4] = (c > run[4]) ? c : run[4];
			run[5] = (c < run[5]) ? c : run[5];
		end
	endtask

	// bounded wait for a store write, then compare its contents
	task automatic await(input bit exp, input int lim);
		bit seen;
		seen = 0;
		for (int k = 0; k < lim && !seen; k++) begin
			@(posedge i_ref_clk);
			seen = (nv_write === 1'b1);
		end
		chk({15'h0000, exp}, {15'h0000, seen});
		if (exp && !seen) begin
			conclude();
		end
		if (seen) begin
			n_wr++;
			chk(16'(n_wr), wr_count);
			chk(16'h0001, 16'(cyc - last_wr >= 60 * CPS));
			for (int i = 0; i < 6; i++) begin
				chk(run[i][15:0], nv_tab[95 - 16 * i -: 16]);
				sto[i] = run[i];
			end
			last_wr = cyc;
		end
	endtask

	// verdict and end of run
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		logic [15:0] rv59[7] = '{16'h0000, 16'h01F4, 16'h0AF0, 16'h1388,
			16'h0000, 16'h0000, 16'h0000};
		logic [15:0] rv66[4] = '{16'h000A, 16'h0019, 16'h0064, 16'h003C};
		void'($urandom(62318));
		smp       = '0;
		i_sys_rst = 1'b1;
		repeat (2) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		last_wr = cyc;
		run = sto;
		repeat (2) @(posedge i_ref_clk);
		for (int i = 0; i < 7; i++) begin
			xs(0, 1, 8'h00, 8'h3B, 8'(2 * i), 16'h0000, 2'b10, rv59[i]);
		end
		for (int i = 0; i < 4; i++) begin
			xs(0, 1, 8'h00, 8'h42, 8'(i), 16'h0000, 2'b10, rv66[i]);
		end
		$display("test reset values done");
		xs(0, 0, 8'h00, 8'h3B, 8'h00, 16'h0000, 2'b01, 16'h0000);
		xs(0, 0, 8'h04, 8'h3B, 8'h02, 16'h0000, 2'b10, 16'h01F4);
		xs(1, 0, 8'h00, 8'h42, 8'h03, 16'h0005, 2'b01, 16'h0000);
		xs(0, 0, 8'h00, 8'h42, 8'h03, 16'h0000, 2'b10, 16'h003C);
		xs(0, 1, 8'h00, 8'h10, 8'h00, 16'h0000, 2'b01, 16'h0000);
		xs(0, 1, 8'h00, 8'h3B, 8'h20, 16'h0000, 2'b10, 16'h0000);
		xs(1, 1, 8'h00, 8'h42, 8'h01, 16'h7730, 2'b10, 16'h0000);
		xs(0, 1, 8'h00, 8'h42, 8'h01, 16'h0000, 2'b10, 16'h0030);
		xs(1, 1, 8'h00, 8'h42, 8'h01, 16'h0019, 2'b10, 16'h0000);
		$display("test access rules done");
		sample(900, 4000, 300);
		await(0, 70 * CPS);
		xs(1, 1, 8'h00, 8'h42, 8'h03, 16'h0000, 2'b10, 16'h0000);
		ivl = 0;
		host.command(16'h0021);
		en = 1;
		@(posedge i_ref_clk);
		chk(16'h0001, {15'h0000, flag});
		sample(900, 4000, 300);
		await(0, 10 * CPS);
		$display("test enable gating done");
		xs(1, 1, 8'h00, 8'h42, 8'h03, 16'h0001, 2'b10, 16'h0000);
		ivl = 1;
		rnd = $urandom_range(25, 0);
		sample(2000, 2800 + rnd, 150 + rnd);
		sample(400, 2800, -50 - rnd);
		await(1, 20 * CPS);
		xs(0, 1, 8'h00, 8'h3B, 8'h0C, 16'h0000, 2'b10, 16'h0001);
		sample(400, 2800, sto[4] + res_c + 1);
		await(1, 70 * CPS);
		$display("test first windows done");
		sample(400, sto[2] + res_v, 0);
		await(0, 70 * CPS);
		sample(sto[1] - res_t - 1, 2800, 0);
		await(1, 70 * CPS);
		$display("test resolution done");
		rnd = $urandom_range(16'h7FFF, 0);
		xs(1, 0, 8'h04, 8'h3B, 8'h04, 16'(rnd), 2'b10, 16'h0000);
		xs(0, 0, 8'h04, 8'h3B, 8'h04, 16'h0000, 2'b10, 16'(rnd));
		chk(16'(rnd), nv_tab.peak_volt);
		$display("test locked write done");
		conclude();
	end
endmodule

// ### dv/lifetime_host_model.sv
// host side of the logger: subcommands and nonvolatile block accesses
// assumes the logger answers an access exactly one cycle after taking it
`timescale 1ns/1ns

module lifetime_host_model (
	// clock
	input  wire logic                  i_ref_clk,
	// answers from the logger
	input  wire logic                  i_ack,
	input  wire logic                  i_refused,
	input  wire logic [15:0]           i_rdata,
	// requests to the logger
	output logic                       o_cmd_valid,
	output logic [15:0]                o_cmd_code,
	output logic                       o_unlocked,
	output logic [7:0]                 o_block_select,
	output lifetime_log_pkg::access_t  o_access
);
	// idle request lines at time zero
	initial begin
		o_cmd_valid    = 1'b0;
		o_cmd_code     = 16'h0000;
		o_unlocked     = 1'b0;
		o_block_select = 8'h00;
		o_access       = '0;
	end

	// one subcommand as a one-cycle strobe
	task automatic command(input logic [15:0] code);
		@(posedge i_ref_clk);
		o_cmd_valid <= 1'b1;
		o_cmd_code  <= code;
		@(posedge i_ref_clk);
		o_cmd_valid <= 1'b0;
		o_cmd_code  <= ~code; // released code lines do not hold
	endtask

	// one access; answer is taken two cycles after the request edge
	task automatic access(input logic wr, input logic unl,
			input logic [7:0] blk, input logic [7:0] sub,
			input logic [7:0] off, input logic [15:0] wd,
			output logic [1:0] ans, output logic [15:0] rd);
		@(posedge i_ref_clk);
		o_unlocked     <= unl;
		o_block_select <= blk;
		o_access       <= {1'b1, wr, sub, off, wd};
		@(posedge i_ref_clk);
		o_access.valid <= 1'b0;
		o_access.wdata <= ~wd; // released data lines do not hold
		@(posedge i_ref_clk);
		ans = {i_ack, i_refused};
		rd  = i_rdata;
	endtask
endmodule

// ### hdl/lifetime_extreme_logger.sv
// lifetime extreme logger: running and stored extremes, throttled commit
// assumes samples and host accesses synchronous to i_ref_clk
`timescale 1ns/1ns
`include "lifetime_log_defines.svh"

module lifetime_extreme_logger #(
	parameter int CYCLES_PER_SECOND = `CYCLES_PER_SECOND
) (
	// clock and reset
	input  wire logic                            i_ref_clk,
	input  wire logic                            i_sys_rst,
	// command and security
	input  wire logic                            i_cmd_valid,
	input  wire logic [15:0]                     i_cmd_code,
	input  wire logic                            i_unlocked,
	input  wire logic [7:0]                      i_block_select,
	// measurements
	input  wire lifetime_log_pkg::sample_t       i_sample,
	// host nonvolatile access
	input  wire lifetime_log_pkg::access_t       i_access,
	output logic [15:0]                          o_rdata,
	output logic                                 o_ack,
	output logic                                 o_refused,
	// status
	output logic                                 o_gauging_enabled_flag,
	output logic                                 o_nv_write,
	output logic [15:0]                          o_log_write_counter,
	output lifetime_log_pkg::extreme_table_t     o_nv_table
);

	lifetime_log_pkg::log_state_t     state_r;
	lifetime_log_pkg::extreme_table_t ram_r;
	lifetime_log_pkg::extreme_table_t nv_r;
	lifetime_log_pkg::extreme_table_t ram_nxt;
	logic [7:0]  temperature_log_threshold_r;
	logic [7:0]  voltage_log_threshold_r;
	logic [7:0]  current_log_threshold_r;
	logic [15:0] log_write_interval_setting_r;
	logic        gauging_enabled_flag_r;
	logic [31:0] tick_cnt_r;
	logic        sec_tick;
	logic [15:0] win_sec_r;
	logic [15:0] gap_sec_r;
	logic        logging_on;
	logic        qualify;
	logic        nv_write_r;
	logic [15:0] log_write_counter_r;
	logic [15:0] rdata_r;
	logic        ack_r;
	logic        refused_r;
	logic        access_ok;
	logic        wr_data_ok;
	logic [5:0]  margin;
	logic [5:0]  beyond;
	logic        any_margin;
	logic        ram_write;

	// signed difference a - b exceeds resolution, strictly
	function automatic logic over_res(input logic [15:0] a,
		input logic [15:0] b, input logic [7:0] res);
		logic signed [17:0] d;
		d = 18'($signed(a)) - 18'($signed(b));
		over_res = d > $signed({10'h000, res});
	endfunction

	// clamp temperature into its documented range
	function automatic logic [15:0] clamp_temp(input logic [15:0] t);
		clamp_temp = t;
		if ($signed(t) < `TEMP_LOW_LIMIT)
			clamp_temp = `TEMP_LOW_LIMIT;
		else if ($signed(t) > `TEMP_HIGH_LIMIT)
			clamp_temp = `TEMP_HIGH_LIMIT;
	endfunction

	// one-second enable; restarting at commit and window open keeps the
	// 60 s spacing and the window length whole seconds, never a fraction
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || sec_tick || state_r == lifetime_log_pkg::ST_COMMIT
			|| (state_r == lifetime_log_pkg::ST_IDLE && qualify))
			tick_cnt_r <= 32'h0000_0000;
		else
			tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
	end
	assign sec_tick = (tick_cnt_r == 32'(CYCLES_PER_SECOND - 1));

	// gauging-enabled flag, set by tracking-enable subcommand
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst)
			gauging_enabled_flag_r <= 1'b0;
		else if (i_cmd_valid && i_cmd_code == `TRACKING_ENABLE_CMD)
			gauging_enabled_flag_r <= 1'b1;
	end
	assign logging_on = gauging_enabled_flag_r
		&& log_write_interval_setting_r != 16'h0000;

	// comparisons of a sample against stored and running tables
	logic [15:0] t_c;
	assign t_c = clamp_temp(i_sample.temperature);
	always_comb begin
		margin[0] = over_res(t_c, nv_r.peak_temp,
			temperature_log_threshold_r);
		margin[1] = over_res(nv_r.low_temp, t_c,
			temperature_log_threshold_r);
		margin[2] = over_res(i_sample.voltage, nv_r.peak_volt,
			voltage_log_threshold_r);
		margin[3] = over_res(nv_r.low_volt, i_sample.voltage,
			voltage_log_threshold_r);
		margin[4] = over_res(i_sample.current, nv_r.peak_chg,
			current_log_threshold_r);
		margin[5] = over_res(nv_r.peak_dsg, i_sample.current,
			current_log_threshold_r);
		beyond[0] = $signed(t_c) > $signed(ram_r.peak_temp);
		beyond[1] = $signed(t_c) < $signed(ram_r.low_temp);
		beyond[2] = $signed(i_sample.voltage) > $signed(ram_r.peak_volt);
		beyond[3] = $signed(i_sample.voltage) < $signed(ram_r.low_volt);
		beyond[4] = $signed(i_sample.current) > $signed(ram_r.peak_chg);
		beyond[5] = $signed(i_sample.current) < $signed(ram_r.peak_dsg);
	end
	assign any_margin = |margin;
	assign qualify = i_sample.valid && logging_on && any_margin
		&& state_r != lifetime_log_pkg::ST_LOAD;

	// running table follows every new extreme while logging is on
	always_comb begin
		ram_nxt = ram_r;
		if (beyond[0]) ram_nxt.peak_temp = t_c;
		if (beyond[1]) ram_nxt.low_temp  = t_c;
		if (beyond[2]) ram_nxt.peak_volt = i_sample.voltage;
		if (beyond[3]) ram_nxt.low_volt  = i_sample.voltage;
		if (beyond[4]) ram_nxt.peak_chg  = i_sample.current;
		if (beyond[5]) ram_nxt.peak_dsg  = i_sample.current;
	end

	// window and throttle state machine
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state_r   <= lifetime_log_pkg::ST_LOAD;
			win_sec_r <= 16'h0000;
		end else begin
			case (state_r)
			lifetime_log_pkg::ST_LOAD:
				state_r <= lifetime_log_pkg::ST_IDLE;
			lifetime_log_pkg::ST_IDLE: begin
				win_sec_r <= 16'h0000;
				if (qualify)
					state_r <= lifetime_log_pkg::ST_WINDOW;
			end
			lifetime_log_pkg::ST_WINDOW: begin
				if (sec_tick)
					win_sec_r <= win_sec_r + 16'h0001;
				if (win_sec_r >= log_write_interval_setting_r
					&& gap_sec_r >= `MIN_WRITE_SPACING_S)
					state_r <= lifetime_log_pkg::ST_COMMIT;
			end
			lifetime_log_pkg::ST_COMMIT:
				state_r <= lifetime_log_pkg::ST_IDLE;
			default:
				state_r <= lifetime_log_pkg::ST_IDLE;
			endcase
		end
	end

	// seconds since last store write, saturating
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || state_r == lifetime_log_pkg::ST_COMMIT)
			gap_sec_r <= 16'h0000;
		else if (sec_tick && gap_sec_r != 16'hFFFF)
			gap_sec_r <= gap_sec_r + 16'h0001;
	end

	// store-table write pulse and counter
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			nv_write_r          <= 1'b0;
			log_write_counter_r <= 16'h0000;
		end else begin
			nv_write_r <= state_r == lifetime_log_pkg::ST_COMMIT;
			if (state_r == lifetime_log_pkg::ST_COMMIT)
				log_write_counter_r <= log_write_counter_r + 16'h0001;
		end
	end

	// host access decode and security gating
	assign access_ok = i_access.subclass == `SUBCLASS_LOGGED_DATA
		? (i_unlocked || i_block_select == `LOCKED_BLOCK_CODE)
		: (i_access.subclass == `SUBCLASS_RESOLUTION
			&& (i_unlocked || !i_access.write));
	assign wr_data_ok = i_access.valid && i_access.write && access_ok;
	assign ram_write = wr_data_ok
		&& i_access.subclass == `SUBCLASS_LOGGED_DATA;

	// stored table: copied from running table on commit, or host written
	// host-written values of entries stay in the stored table only; a commit
	// overwrites them with the running table, and reset with the reset values
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			nv_r.peak_temp <= `RST_PEAK_TEMP;
			nv_r.low_temp  <= `RST_LOW_TEMP;
			nv_r.peak_volt <= `RST_PEAK_VOLT;
			nv_r.low_volt  <= `RST_LOW_VOLT;
			nv_r.peak_chg  <= `RST_PEAK_CUR;
			nv_r.peak_dsg  <= `RST_PEAK_CUR;
		end else if (state_r == lifetime_log_pkg::ST_COMMIT) begin
			nv_r <= ram_r;
		end else if (ram_write) begin
			case (i_access.offset)
			`OFF_PEAK_TEMP: nv_r.peak_temp <= i_access.wdata;
			`OFF_LOW_TEMP:  nv_r.low_temp  <= i_access.wdata;
			`OFF_PEAK_VOLT: nv_r.peak_volt <= i_access.wdata;
			`OFF_LOW_VOLT:  nv_r.low_volt  <= i_access.wdata;
			`OFF_PEAK_CHG:  nv_r.peak_chg  <= i_access.wdata;
			`OFF_PEAK_DSG:  nv_r.peak_dsg  <= i_access.wdata;
			default: ;
			endcase
		end
	end

	// running table: loaded from store after reset, then tracks samples
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst)
			ram_r <= '0;
		else if (state_r == lifetime_log_pkg::ST_LOAD)
			ram_r <= nv_r;
		else if (i_sample.valid && logging_on)
			ram_r <= ram_nxt;
	end

	// resolution settings, writable unlocked only
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			temperature_log_threshold_r  <= `RST_TEMP_RES;
			voltage_log_threshold_r      <= `RST_VOLT_RES;
			current_log_threshold_r      <= `RST_CUR_RES;
			log_write_interval_setting_r <= `RST_INTERVAL;
		end else if (wr_data_ok
			&& i_access.subclass == `SUBCLASS_RESOLUTION) begin
			case (i_access.offset)
			`OFF_TEMP_RES: temperature_log_threshold_r <= i_access.wdata[7:0];
			`OFF_VOLT_RES: voltage_log_threshold_r <= i_access.wdata[7:0];
			`OFF_CUR_RES:  current_log_threshold_r <= i_access.wdata[7:0];
			`OFF_INTERVAL: log_write_interval_setting_r <= i_access.wdata;
			default: ;
			endcase
		end
	end

	// read data, acknowledge and refusal, one cycle after request
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			rdata_r   <= 16'h0000;
			ack_r     <= 1'b0;
			refused_r <= 1'b0;
		end else begin
			ack_r     <= i_access.valid && access_ok;
			refused_r <= i_access.valid && !access_ok;
			rdata_r   <= 16'h0000;
			if (i_access.valid && access_ok && !i_access.write) begin
				if (i_access.subclass == `SUBCLASS_LOGGED_DATA) begin
					case (i_access.offset)
					`OFF_PEAK_TEMP:   rdata_r <= nv_r.peak_temp;
					`OFF_LOW_TEMP:    rdata_r <= nv_r.low_temp;
					`OFF_PEAK_VOLT:   rdata_r <= nv_r.peak_volt;
					`OFF_LOW_VOLT:    rdata_r <= nv_r.low_volt;
					`OFF_PEAK_CHG:    rdata_r <= nv_r.peak_chg;
					`OFF_PEAK_DSG:    rdata_r <= nv_r.peak_dsg;
					`OFF_WRITE_COUNT: rdata_r <= log_write_counter_r;
					default:          rdata_r <= 16'h0000;
					endcase
				end else begin
					case (i_access.offset)
					`OFF_TEMP_RES: rdata_r <= {8'h00, temperature_log_threshold_r};
					`OFF_VOLT_RES: rdata_r <= {8'h00, voltage_log_threshold_r};
					`OFF_CUR_RES:  rdata_r <= {8'h00, current_log_threshold_r};
					`OFF_INTERVAL: rdata_r <= log_write_interval_setting_r;
					default:       rdata_r <= 16'h0000;
					endcase
				end
			end
		end
	end

	// outputs
	assign o_rdata                = rdata_r;
	assign o_ack                  = ack_r;
	assign o_refused              = refused_r;
	assign o_gauging_enabled_flag = gauging_enabled_flag_r;
	assign o_nv_write             = nv_write_r;
	assign o_log_write_counter    = log_write_counter_r;
	assign o_nv_table             = nv_r;

	// checks
	a_no_log_disabled: assert property (@(posedge i_ref_clk)
		disable iff (i_sys_rst)
		!logging_on |-> state_r != lifetime_log_pkg::ST_WINDOW
			|| $past(state_r) == lifetime_log_pkg::ST_WINDOW)
		else $error("window opened while logging off");
	a_zero_interval: assert property (@(posedge i_ref_clk)
		disable iff (i_sys_rst)
		(state_r == lifetime_log_pkg::ST_IDLE
			&& log_write_interval_setting_r == 16'h0000)
		|=> state_r != lifetime_log_pkg::ST_WINDOW)
		else $error("window opened with zero interval");
	a_window_opens: assert property (@(posedge i_ref_clk)
		disable iff (i_sys_rst)
		(state_r == lifetime_log_pkg::ST_IDLE && qualify)
		|=> state_r == lifetime_log_pkg::ST_WINDOW)
		else $error("qualifying extreme did not open window");
	a_commit_spacing: assert property (@(posedge i_ref_clk)
		disable iff (i_sys_rst)
		state_r == lifetime_log_pkg::ST_COMMIT
		|-> gap_sec_r >= `MIN_WRITE_SPACING_S
			&& win_sec_r >= log_write_interval_setting_r)
		else $error("store write too early");
	a_copy_table: assert property (@(posedge i_ref_clk)
		disable iff (i_sys_rst)
		state_r == lifetime_log_pkg::ST_COMMIT |=> nv_r == $past(ram_r)
			&& nv_write_r)
		else $error("store not copied from running table");
	a_count_writes: assert property (@(posedge i_ref_clk)
		disable iff (i_sys_rst)
		nv_write_r |-> log_write_counter_r
			== $past(log_write_counter_r) + 16'h0001)
		else $error("write counter not advanced");
	a_res_locked: assert property (@(posedge i_ref_clk)
		disable iff (i_sys_rst)
		(i_access.valid && i_access.write && !i_unlocked
			&& i_access.subclass == `SUBCLASS_RESOLUTION)
		|=> refused_r && $stable(log_write_interval_setting_r))
		else $error("locked resolution write accepted");
	a_peak_tracks: assert property (@(posedge i_ref_clk)
		disable iff (i_sys_rst)
		(i_sample.valid && logging_on && beyond[2]
			&& state_r != lifetime_log_pkg::ST_LOAD)
		|=> ram_r.peak_volt == $past(i_sample.voltage))
		else $error("running peak voltage not updated");
	c_window: cover property (@(posedge i_ref_clk)
		state_r == lifetime_log_pkg::ST_WINDOW);
	c_commit: cover property (@(posedge i_ref_clk) nv_write_r);
	c_locked_read: cover property (@(posedge i_ref_clk)
		ack_r && !i_unlocked);

endmodule

// ### hdl/lifetime_log_defines.svh
// offsets, reset values and timing counts of the lifetime extreme logger
// assumes inclusion by bare name from the logger module
`ifndef LIFETIME_LOG_DEFINES_SVH
`define LIFETIME_LOG_DEFINES_SVH

// subclass identifiers, block code and tracking-enable subcommand
`define SUBCLASS_LOGGED_DATA   8'h3B
`define SUBCLASS_RESOLUTION    8'h42
`define LOCKED_BLOCK_CODE      8'h04
`define TRACKING_ENABLE_CMD    16'h0021

// logged-data offsets (bytes within subclass 59)
`define OFF_PEAK_TEMP          8'h00
`define OFF_LOW_TEMP           8'h02
`define OFF_PEAK_VOLT          8'h04
`define OFF_LOW_VOLT           8'h06
`define OFF_PEAK_CHG           8'h08
`define OFF_PEAK_DSG           8'h0A
`define OFF_WRITE_COUNT        8'h0C
// resolution offsets (bytes within subclass 66)
`define OFF_TEMP_RES           8'h00
`define OFF_VOLT_RES           8'h01
`define OFF_CUR_RES            8'h02
`define OFF_INTERVAL           8'h03

// reset values of stored entries and resolution settings
`define RST_PEAK_TEMP          16'h0000
`define RST_LOW_TEMP           16'h01F4
`define RST_PEAK_VOLT          16'h0AF0
`define RST_LOW_VOLT           16'h1388
`define RST_PEAK_CUR           16'h0000
`define RST_TEMP_RES           8'h0A
`define RST_VOLT_RES           8'h19
`define RST_CUR_RES            8'h64
`define RST_INTERVAL           16'h003C

// temperature limits in 0.1 degC
`define TEMP_LOW_LIMIT         (-16'sd600)
`define TEMP_HIGH_LIMIT        (16'sd1400)

// one second at 250 MHz
`define CLK_PERIOD_NS          4
`define SECOND_NS              1000000000
`define CYCLES_PER_SECOND      (`SECOND_NS / `CLK_PERIOD_NS)
// throttle floor in seconds
`define MIN_WRITE_SPACING_S    16'd60

`endif

// ### hdl/lifetime_log_pkg.sv
// types shared by the lifetime extreme logger
// assumes the defines header is compiled with it
package lifetime_log_pkg;

	// one measurement sample
	typedef struct packed {
		logic        valid;
		logic [15:0] temperature;
		logic [15:0] voltage;
		logic [15:0] current;
	} sample_t;

	// table of six extremes
	typedef struct packed {
		logic [15:0] peak_temp;
		logic [15:0] low_temp;
		logic [15:0] peak_volt;
		logic [15:0] low_volt;
		logic [15:0] peak_chg;
		logic [15:0] peak_dsg;
	} extreme_table_t;

	// host access request
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  subclass;
		logic [7:0]  offset;
		logic [15:0] wdata;
	} access_t;

	// logger states
	typedef enum logic [1:0] {
		ST_LOAD,
		ST_IDLE,
		ST_WINDOW,
		ST_COMMIT
	} log_state_t;

endpackage
